/* dlpd_led_panel.sv */
/*
 * LED panel model: counts lit samples and level changes of every LED in a window.
 * Assumes the bench opens and shuts window_i away from the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module dlpd_led_panel
    import dlpd_pkg::*;
(
    // Clock and window
    input  wire logic          clock_i,
    input  wire logic          window_i,
    // LED drives
    input  wire dlpd_leds_type leds_i,
    // Counts per LED
    output var  int            lit_o [12],
    output var  int            flip_o [12]
);
    logic [11:0] last;

    // Count while the window is open, clear while it is shut; unknown levels count as lit and changing
    always_ff @(posedge clock_i) begin
        last <= leds_i;
        for (int i = 0; i < 12; i++) begin
            if (window_i) begin
                lit_o[i]  <= lit_o[i] + int'(leds_i[i] !== 1'b0);
                flip_o[i] <= flip_o[i] + int'(leds_i[i] !== last[i] || $isunknown(leds_i[i]));
            end else begin
                lit_o[i]  <= 0;
                flip_o[i] <= 0;
            end
        end
    end
endmodule
`default_nettype wire

/* dlpd_map.svh */
/*
 * Constants of the diagnostic LED pattern driver: pattern timing and reset values.
 * Assumes it is included by bare name into the top module.
 */
`ifndef DLPD_MAP_SVH
`define DLPD_MAP_SVH

// ----------------------------------------------------------------------------
// Pattern timing, counted in prescaler ticks
// ----------------------------------------------------------------------------
`define DLPD_PRESCALE_W    16
`define DLPD_PHASE_W       6
`define DLPD_RAPID_BIT     0
`define DLPD_FLASH_BIT     2
`define DLPD_SLOW_BIT      3
`define DLPD_BURST_BIT     5
`define DLPD_SLOT_LSB      2
`define DLPD_SLOT_MSB      4
`define DLPD_SLOT_ON_BIT   1
`define DLPD_BLINK_SLOT    3'h0
`define DLPD_CHASE_STEPS   2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DLPD_PHASE_RST     6'h00
`define DLPD_PRESCALE_RST  16'h0000

`endif

/* dlpd_pkg.sv */
/*
 * Types of the diagnostic LED pattern driver: state codes and LED carriers.
 * Assumes software drives the state inputs with these codes.
 */
package dlpd_pkg;

    // ------------------------------------------------------------------------
    // State codes from software
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        DLPD_BUS_NO_LINK = 3'h0,
        DLPD_BUS_SETUP   = 3'h1,
        DLPD_BUS_DHCP    = 3'h2,
        DLPD_BUS_WAIT    = 3'h3,
        DLPD_BUS_RUN     = 3'h4
    } dlpd_bus_type;

    typedef enum logic [2:0] {
        DLPD_SAFE_PRE_RESET = 3'h0,
        DLPD_SAFE_RESET     = 3'h1,
        DLPD_SAFE_SESSION   = 3'h2,
        DLPD_SAFE_CONN      = 3'h3,
        DLPD_SAFE_PARAM     = 3'h4,
        DLPD_SAFE_PROCESS   = 3'h5,
        DLPD_SAFE_FAILSAFE  = 3'h6,
        DLPD_SAFE_ERROR     = 3'h7
    } dlpd_safe_type;

    typedef enum logic [1:0] {
        DLPD_AX_IDLE    = 2'h0,
        DLPD_AX_READY   = 2'h1,
        DLPD_AX_ENABLED = 2'h2,
        DLPD_AX_FAULT   = 2'h3
    } dlpd_axis_type;

    // Firmware phase, Gray coded along start, normal, erase, copy, fail
    typedef enum logic [2:0] {
        DLPD_FW_START  = 3'b000,
        DLPD_FW_NORMAL = 3'b001,
        DLPD_FW_ERASE  = 3'b011,
        DLPD_FW_COPY   = 3'b010,
        DLPD_FW_FAIL   = 3'b110
    } dlpd_fw_type;

    typedef enum logic [2:0] {
        DLPD_PAT_OFF, DLPD_PAT_ON, DLPD_PAT_FLASH, DLPD_PAT_FLASH_INV,
        DLPD_PAT_SLOW, DLPD_PAT_RAPID, DLPD_PAT_BLINK, DLPD_PAT_COUNT
    } dlpd_pat_type;

    // Per-axis state bundle
    typedef struct packed {
        dlpd_axis_type state;
        logic          warning;
        logic          config_ok;
    } dlpd_axis_in_type;

    // All LED drives, one bit each
    typedef struct packed {
        logic       bus_fault_led;
        logic       bus_run_led;
        logic       safety_led;
        logic       ctrl_run_led;
        logic       err_a_led;
        logic       err_b_led;
        logic       svc_link_led;
        logic       svc_act_led;
        logic [1:0] port_link_activity_led;
        logic [1:0] port_yellow_led;
    } dlpd_leds_type;

endpackage

/* dlpd_top.sv */
/*
 * Diagnostic LED pattern driver: maps drive states to LED patterns.
 * Assumes software keeps the state inputs synchronous to clock_i and the LEDs
 * are driven directly from leds_o.
 */
// What this block does
// RQ1 - Bus fault LED: off no error, rapid no data exchange, on without link.
// RQ2 - Bus run LED: off, flash setup, inverse for DHCP, slow waiting, on connected.
// RQ3 - Safety LED: off pre-reset, flash setup states, on process, blink failsafe.
// RQ4 - Safety errors: rapid blinking then one to six counted flashes per error code.
// RQ5 - Run LED off without supply or on axis fault; single blink in safe_torque_off.
// RQ6 - Run LED flashes when an axis ready, lit when an axis enabled, none faulty.
// RQ7 - Run LED flashes rapidly while memory and card are being written.
// RQ8 - Axis error LEDs: off, flash warning, on fault, rapid without configuration.
// RQ9 - Firmware start-up lights run and both error LEDs.
// RQ10 - Normal run and error display continues during live update.
// RQ11 - Distinct rapid combinations for erase and copy; chaser on update failure.
// RQ12 - Service link LED lit only while a connection is present.
// RQ13 - Service activity LED: off, flash single packets, on continuous exchange.
// RQ14 - Variant one: green flashes on exchange, lit when linked; yellow unused.
// RQ15 - Variant two: green lit when linked; yellow flashes on data exchange.
// RQ16 - Bus link state readable as a status output.
// RQ17 - Safety link state readable as a status output.
// RQ18 - One programmable prescaler times every pattern so LEDs stay in phase.
`timescale 1ns/1ps
`default_nettype none
`include "dlpd_map.svh"

module dlpd_top
    import dlpd_pkg::*;
(
    // Clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        reset_i,
    // Timing
    input  wire logic [`DLPD_PRESCALE_W-1:0] prescale_i,
    // Fieldbus and safety link
    input  wire dlpd_bus_type                bus_state_i,
    input  wire dlpd_safe_type               safe_state_i,
    input  wire logic [2:0]                  safe_err_code_i,
    // Drive controller
    input  wire logic                        supply_ok_i,
    input  wire logic                        safe_torque_off_i,
    input  wire logic                        mem_write_i,
    input  wire logic                        double_axis_i,
    input  wire dlpd_axis_in_type            axis_a_i,
    input  wire dlpd_axis_in_type            axis_b_i,
    // Firmware phases
    input  wire logic                        startup_done_i,
    input  wire dlpd_fw_type                 fw_req_i,
    // Service port
    input  wire logic                        svc_link_i,
    input  wire logic                        svc_packet_i,
    input  wire logic                        svc_stream_i,
    // Fieldbus ports
    input  wire logic                        fb_variant_i,
    input  wire logic [1:0]                  fb_link_i,
    input  wire logic [1:0]                  fb_activity_i,
    // Outputs
    output var  dlpd_leds_type               leds_o,
    output var  dlpd_bus_type                bus_link_state_parameter_o,
    output var  logic [5:0]                  safety_link_status_parameter_o
);

    // ------------------------------------------------------------------------
    // Pattern helper
    // ------------------------------------------------------------------------
    // Picks one pattern's current level out of the shared pattern vector
    function automatic logic pat_bit(input dlpd_pat_type p, input logic [7:0] w);
        pat_bit = w[p];
    endfunction

    // ------------------------------------------------------------------------
    // Shared prescaler and phase
    // ------------------------------------------------------------------------
    logic [`DLPD_PRESCALE_W-1:0] pre_cnt;
    logic                        tick;
    logic [`DLPD_PHASE_W-1:0]    phase;
    logic [1:0]                  chase;
    dlpd_fw_type                 mode;
    dlpd_fw_type                 next_mode;
    logic [7:0]                  pat_w;
    logic [2:0]                  slot;
    dlpd_leds_type               next_leds;

    // Tick once every prescale_i+1 clocks
    always_ff @(posedge clock_i) begin
        tick <= !reset_i && (pre_cnt >= prescale_i);
        if (reset_i || (pre_cnt >= prescale_i)) begin
            pre_cnt <= `DLPD_PRESCALE_RST; // RQ18
        end else begin
            pre_cnt <= pre_cnt + 16'h0001;
        end
    end

    // Phase frame and chaser position advance on ticks
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            phase <= `DLPD_PHASE_RST;
            chase <= 2'h0;
        end else if (tick) begin
            phase <= phase + 6'h01; // RQ18
            if (phase[1:0] == 2'h3) begin
                chase <= (chase == `DLPD_CHASE_STEPS - 2'h1) ? 2'h0 : chase + 2'h1;
            end
        end
    end

    // Pattern levels, all from the same phase so LEDs blink together
    assign slot = phase[`DLPD_SLOT_MSB:`DLPD_SLOT_LSB];
    always_comb begin
        pat_w                     = 8'h00; // Off pattern stays low
        pat_w[DLPD_PAT_ON]        = 1'b1;
        pat_w[DLPD_PAT_FLASH]     = phase[`DLPD_FLASH_BIT];
        pat_w[DLPD_PAT_FLASH_INV] = ~phase[`DLPD_FLASH_BIT];
        pat_w[DLPD_PAT_SLOW]      = phase[`DLPD_SLOW_BIT];
        pat_w[DLPD_PAT_RAPID]     = phase[`DLPD_RAPID_BIT];
        pat_w[DLPD_PAT_BLINK]     = (phase[`DLPD_PHASE_W-1:3] == `DLPD_BLINK_SLOT);
        // First half rapid blinking, second half counted flashes
        pat_w[DLPD_PAT_COUNT]     = phase[`DLPD_BURST_BIT]
                                  ? ((slot < safe_err_code_i) && phase[`DLPD_SLOT_ON_BIT])
                                  : phase[`DLPD_RAPID_BIT]; // RQ4
    end

    // ------------------------------------------------------------------------
    // Firmware phase machine
    // ------------------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        unique case (mode)
            DLPD_FW_START: next_mode = startup_done_i ? DLPD_FW_NORMAL : DLPD_FW_START; // RQ9
            DLPD_FW_NORMAL, DLPD_FW_ERASE, DLPD_FW_COPY: begin
                if (fw_req_i != DLPD_FW_START) begin
                    next_mode = fw_req_i; // RQ10
                end
            end
            DLPD_FW_FAIL: next_mode = DLPD_FW_FAIL; // RQ11
            default: begin
                next_mode = DLPD_FW_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mode <= DLPD_FW_START;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------------
    // LED pattern selection
    // ------------------------------------------------------------------------
    always_comb begin
        dlpd_pat_type p_bf;
        dlpd_pat_type p_run;
        dlpd_pat_type p_safe;
        dlpd_pat_type p_ctrl;
        dlpd_pat_type p_ea;
        dlpd_pat_type p_eb;
        logic         any_fault;
        logic         any_enabled;
        logic         any_ready;
        p_bf        = DLPD_PAT_OFF;
        p_run       = DLPD_PAT_OFF;
        p_safe      = DLPD_PAT_OFF;
        p_ctrl      = DLPD_PAT_OFF;
        p_ea        = DLPD_PAT_OFF;
        p_eb        = DLPD_PAT_OFF;
        any_fault   = (axis_a_i.state == DLPD_AX_FAULT)
                    || (double_axis_i && axis_b_i.state == DLPD_AX_FAULT);
        any_enabled = (axis_a_i.state == DLPD_AX_ENABLED)
                    || (double_axis_i && axis_b_i.state == DLPD_AX_ENABLED);
        any_ready   = (axis_a_i.state == DLPD_AX_READY)
                    || (double_axis_i && axis_b_i.state == DLPD_AX_READY);
        next_leds   = '0;

        // Bus fault and bus run
        unique case (bus_state_i)
            DLPD_BUS_NO_LINK: begin
                p_bf  = DLPD_PAT_ON; // RQ1
                p_run = DLPD_PAT_OFF; // RQ2
            end
            DLPD_BUS_SETUP: begin
                p_bf  = DLPD_PAT_RAPID; // RQ1
                p_run = DLPD_PAT_FLASH; // RQ2
            end
            DLPD_BUS_DHCP: begin
                p_bf  = DLPD_PAT_RAPID; // RQ1
                p_run = DLPD_PAT_FLASH_INV; // RQ2
            end
            DLPD_BUS_WAIT: begin
                p_bf  = DLPD_PAT_RAPID; // RQ1
                p_run = DLPD_PAT_SLOW; // RQ2
            end
            DLPD_BUS_RUN: begin
                p_bf  = DLPD_PAT_OFF; // RQ1
                p_run = DLPD_PAT_ON; // RQ2
            end
            default: begin
                p_bf  = DLPD_PAT_ON;
                p_run = DLPD_PAT_OFF;
            end
        endcase

        // Safety link
        unique case (safe_state_i)
            DLPD_SAFE_PRE_RESET: p_safe = DLPD_PAT_OFF; // RQ3
            DLPD_SAFE_RESET, DLPD_SAFE_SESSION,
            DLPD_SAFE_CONN, DLPD_SAFE_PARAM: p_safe = DLPD_PAT_FLASH; // RQ3
            DLPD_SAFE_PROCESS: p_safe = DLPD_PAT_ON; // RQ3
            DLPD_SAFE_FAILSAFE: p_safe = DLPD_PAT_BLINK; // RQ3
            DLPD_SAFE_ERROR: p_safe = DLPD_PAT_COUNT; // RQ4
        endcase

        // Controller run, off states win over every other run pattern
        if (!supply_ok_i || any_fault) begin
            p_ctrl = DLPD_PAT_OFF; // RQ5
        end else if (mem_write_i) begin
            p_ctrl = DLPD_PAT_RAPID; // RQ7
        end else if (safe_torque_off_i) begin
            p_ctrl = DLPD_PAT_BLINK; // RQ5
        end else if (any_enabled) begin
            p_ctrl = DLPD_PAT_ON; // RQ6
        end else if (any_ready) begin
            p_ctrl = DLPD_PAT_FLASH; // RQ6
        end

        // Axis error LEDs, missing configuration shown first
        if (!axis_a_i.config_ok) begin
            p_ea = DLPD_PAT_RAPID; // RQ8
        end else if (axis_a_i.state == DLPD_AX_FAULT) begin
            p_ea = DLPD_PAT_ON; // RQ8
        end else if (axis_a_i.warning) begin
            p_ea = DLPD_PAT_FLASH; // RQ8
        end
        if (!double_axis_i) begin
            p_eb = DLPD_PAT_OFF; // RQ8
        end else if (!axis_b_i.config_ok) begin
            p_eb = DLPD_PAT_RAPID;
        end else if (axis_b_i.state == DLPD_AX_FAULT) begin
            p_eb = DLPD_PAT_ON;
        end else if (axis_b_i.warning) begin
            p_eb = DLPD_PAT_FLASH;
        end

        next_leds.bus_fault_led = pat_bit(p_bf, pat_w);
        next_leds.bus_run_led   = pat_bit(p_run, pat_w);
        next_leds.safety_led    = pat_bit(p_safe, pat_w);

        // Firmware phases override the three controller LEDs
        unique case (mode)
            DLPD_FW_START: begin
                next_leds.ctrl_run_led = 1'b1; // RQ9
                next_leds.err_a_led    = 1'b1;
                next_leds.err_b_led    = 1'b1;
            end
            DLPD_FW_ERASE: begin
                next_leds.ctrl_run_led = 1'b0; // RQ11
                next_leds.err_a_led    = pat_w[DLPD_PAT_RAPID];
                next_leds.err_b_led    = 1'b0;
            end
            DLPD_FW_COPY: begin
                next_leds.ctrl_run_led = pat_w[DLPD_PAT_RAPID]; // RQ11
                next_leds.err_a_led    = 1'b0;
                next_leds.err_b_led    = 1'b0;
            end
            DLPD_FW_FAIL: begin
                next_leds.ctrl_run_led = (chase == 2'h0); // RQ11
                next_leds.err_a_led    = (chase == 2'h1);
                next_leds.err_b_led    = (chase == 2'h2);
            end
            default: begin
                next_leds.ctrl_run_led = pat_bit(p_ctrl, pat_w); // RQ10
                next_leds.err_a_led    = pat_bit(p_ea, pat_w);
                next_leds.err_b_led    = pat_bit(p_eb, pat_w);
            end
        endcase

        // Service port
        next_leds.svc_link_led = svc_link_i; // RQ12
        next_leds.svc_act_led  = svc_link_i && (svc_stream_i
                               || (svc_packet_i && pat_w[DLPD_PAT_FLASH])); // RQ13

        // Fieldbus ports
        for (int i = 0; i < 2; i++) begin
            if (!fb_variant_i) begin
                next_leds.port_link_activity_led[i] = fb_link_i[i]
                    && (!fb_activity_i[i] || pat_w[DLPD_PAT_FLASH]); // RQ14
                next_leds.port_yellow_led[i] = 1'b0; // RQ14
            end else begin
                next_leds.port_link_activity_led[i] = fb_link_i[i]; // RQ15
                next_leds.port_yellow_led[i] = fb_activity_i[i] && pat_w[DLPD_PAT_FLASH]; // RQ15
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            leds_o <= '0;
        end else begin
            leds_o <= next_leds;
        end
    end

    // Status parameters mirror the displayed link states
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus_link_state_parameter_o     <= DLPD_BUS_NO_LINK;
            safety_link_status_parameter_o <= 6'h00;
        end else begin
            bus_link_state_parameter_o     <= bus_state_i; // RQ16
            safety_link_status_parameter_o <= {safe_state_i, safe_err_code_i}; // RQ17
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_no_link;
        bus_state_i == DLPD_BUS_NO_LINK;
    endsequence
    sequence s_linked;
        bus_state_i == DLPD_BUS_RUN;
    endsequence
    sequence s_start_done;
        ##1 mode == DLPD_FW_NORMAL;
    endsequence

    AST_BF_NOLINK: assert property (s_no_link |=> leds_o.bus_fault_led && !leds_o.bus_run_led) // RQ1
        else $error("bus fault LED not lit without link");
    AST_BUS_RUN: assert property (s_linked |=> !leds_o.bus_fault_led && leds_o.bus_run_led) // RQ2
        else $error("bus LEDs wrong while connected");
    AST_SAFE_PROC: assert property (safe_state_i == DLPD_SAFE_PROCESS |=> leds_o.safety_led) // RQ3
        else $error("safety LED not lit in process data");
    AST_SAFE_PRE: assert property (safe_state_i == DLPD_SAFE_PRE_RESET |=> !leds_o.safety_led) // RQ3
        else $error("safety LED lit in pre-reset");
    AST_RUN_OFF: assert property ((mode == DLPD_FW_NORMAL) && !supply_ok_i |=> !leds_o.ctrl_run_led) // RQ5
        else $error("run LED lit without supply");
    AST_ERR_FAULT: assert property ((mode == DLPD_FW_NORMAL) && axis_a_i.config_ok
                                    && axis_a_i.state == DLPD_AX_FAULT |=> leds_o.err_a_led) // RQ8
        else $error("axis A fault not shown");
    AST_START: assert property (mode == DLPD_FW_START
                                |=> leds_o.ctrl_run_led && leds_o.err_a_led && leds_o.err_b_led) // RQ9
        else $error("start-up pattern not shown");
    AST_START_EXIT: assert property ((mode == DLPD_FW_START) && startup_done_i |-> s_start_done) // RQ9
        else $error("start-up phase not left");
    AST_FAIL_HOLD: assert property (mode == DLPD_FW_FAIL |=> mode == DLPD_FW_FAIL) // RQ11
        else $error("update failure state left");
    AST_SVC_LINK: assert property (svc_link_i != $past(svc_link_i) |=> leds_o.svc_link_led == $past(svc_link_i)) // RQ12
        else $error("service link LED wrong");
    AST_FB_YELLOW: assert property (!fb_variant_i |=> leds_o.port_yellow_led == 2'h0) // RQ14
        else $error("yellow LED used in first variant");
    AST_BUS_PARAM: assert property (1'b1 |=> bus_link_state_parameter_o == $past(bus_state_i)) // RQ16
        else $error("bus state parameter stale");
    AST_TICK_GAP: assert property ((prescale_i != 16'h0000) && $stable(prescale_i) && tick |=> !tick) // RQ18
        else $error("prescaler ticks back to back");
endmodule

`default_nettype wire

/* dlpd_top_tb_top.sv */
/*
 * Testbench of the LED pattern driver: one task per scenario, judged by LED counts, sampled LED levels and status parameters.
 * Assumes a tick every 2 clocks, so a 256-clock window spans two full phase cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module dlpd_top_tb_top
    import dlpd_pkg::*;
;
    // ------------------------------------------------------------------------
    // Signals and expected counts: off, on, flash, slow, rapid, blink, counted 0..6
    // ------------------------------------------------------------------------
    logic clock_i, reset_i, supply, safe_torque_off, mem_wr, dbl, startup, window;
    logic svc_link, svc_pkt, svc_str, variant;
    logic [1:0] fb_link, fb_act;
    logic [2:0] code;
    dlpd_bus_type bus, bus_par;
    dlpd_safe_type safe;
    dlpd_axis_in_type ax_a, ax_b;
    dlpd_fw_type fw;
    dlpd_leds_type leds;
    logic [5:0] safe_par;
    logic [15:0] pre;
    int lit [12];
    int flip [12];
    int err_count = 0;
    int tests_run = 0;
    localparam int HI [13] = '{0, 256, 128, 128, 128, 32, 64, 72, 80, 88, 96, 104, 112};
    localparam int TG [13] = '{0, 0, 32, 16, 128, 4, 64, 68, 72, 76, 80, 84, 88};

    dlpd_top dut (.clock_i(clock_i), .reset_i(reset_i), .prescale_i(pre), .bus_state_i(bus),
        .safe_state_i(safe), .safe_err_code_i(code), .supply_ok_i(supply), .safe_torque_off_i(safe_torque_off),
        .mem_write_i(mem_wr), .double_axis_i(dbl), .axis_a_i(ax_a), .axis_b_i(ax_b),
        .startup_done_i(startup), .fw_req_i(fw), .svc_link_i(svc_link), .svc_packet_i(svc_pkt),
        .svc_stream_i(svc_str), .fb_variant_i(variant), .fb_link_i(fb_link), .fb_activity_i(fb_act),
        .leds_o(leds), .bus_link_state_parameter_o(bus_par), .safety_link_status_parameter_o(safe_par));

    dlpd_led_panel panel (.clock_i(clock_i), .window_i(window), .leds_i(leds), .lit_o(lit), .flip_o(flip));

    // Clock of 4 ns
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Let outputs settle, then count over two full phase cycles
    task measure;
        repeat (8) @(negedge clock_i);
        window = 1'b1;
        repeat (256) @(negedge clock_i);
        window = 1'b0;
    endtask

    task chk(input int b, input int p);
        tests_run++;
        if (lit[b] != HI[p] || flip[b] != TG[p]) begin
            err_count++;
            $display("BAD led%0d exp %0d/%0d seen %0d/%0d", b, HI[p], TG[p], lit[b], flip[b]);
        end
    endtask

    task same(input string n, input logic [5:0] e, input logic [5:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask

    task t_start;
        measure();
        chk(8, 1);
        chk(7, 1);
        chk(6, 1);
        startup = 1'b1;
        $display("test start done");
    endtask

    task t_bus;
        int f [5] = '{1, 4, 4, 4, 0};
        int r [5] = '{0, 2, 2, 3, 1};
        for (int i = 0; i < 5; i++) begin
            bus = dlpd_bus_type'(i);
            measure();
            chk(11, f[i]);
            chk(10, r[i]);
            same("bus_param", {3'h0, bus}, {3'h0, bus_par});
        end
        // Inverse flash must be the exact complement of the shared flash phase
        safe = DLPD_SAFE_RESET;
        bus = DLPD_BUS_DHCP;
        repeat (8) @(negedge clock_i);
        repeat (64) @(negedge clock_i) same("inverse", {5'h00, ~leds.safety_led}, {5'h00, leds.bus_run_led});
        $display("test bus done");
    endtask

    task t_safe;
        int sp [7] = '{0, 2, 2, 2, 2, 1, 5};
        for (int i = 0; i < 7; i++) begin
            safe = dlpd_safe_type'(i);
            measure();
            chk(9, sp[i]);
            same("safe_param", {safe, code}, safe_par);
        end
        safe = DLPD_SAFE_ERROR;
        for (int k = 0; k < 7; k++) begin
            code = k[2:0];
            measure();
            chk(9, 6 + k);
            same("safe_param", {safe, code}, safe_par);
        end
        $display("test safety done");
    endtask

    task t_run;
        logic [6:0] sup = 7'b1111110;
        logic [6:0] st = 7'b0000100;
        logic [6:0] mw = 7'b1000010;
        logic [6:0] db = 7'b0100000;
        logic [1:0] as [7] = '{2'h1, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
        logic [1:0] bs [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0};
        int ex [7] = '{0, 0, 5, 2, 1, 0, 4};
        for (int i = 0; i < 7; i++) begin
            {supply, safe_torque_off, mem_wr, dbl} = {sup[i], st[i], mw[i], db[i]};
            ax_a = {as[i], 2'h1};
            ax_b = {bs[i], 2'h1};
            measure();
            chk(8, ex[i]);
        end
        {supply, mem_wr, dbl} = 3'b100;
        $display("test run done");
    endtask

    task t_err;
        logic [3:0] av [4] = '{4'h1, 4'h3, 4'hF, 4'hC};
        logic [3:0] bv [4] = '{4'h1, 4'hD, 4'hD, 4'hC};
        int ea [4] = '{0, 2, 1, 4};
        int eb [4] = '{0, 0, 1, 4};
        for (int i = 0; i < 4; i++) begin
            ax_a = av[i];
            ax_b = bv[i];
            dbl = (i > 1);
            measure();
            chk(7, ea[i]);
            chk(6, eb[i]);
        end
        $display("test error done");
    endtask

    task t_ports;
        logic [7:0] cf [3] = '{8'h63, 8'hCD, 8'hF6};
        int bit_of [6] = '{5, 4, 2, 3, 0, 1};
        int ex [3][6] = '{'{0, 0, 0, 0, 0, 0}, '{1, 2, 2, 1, 0, 0}, '{1, 1, 1, 0, 0, 2}};
        for (int i = 0; i < 3; i++) begin
            {svc_link, svc_pkt, svc_str, variant, fb_link, fb_act} = cf[i];
            measure();
            for (int j = 0; j < 6; j++) chk(bit_of[j], ex[i][j]);
        end
        // A tick every 4 clocks stretches the yellow flash to the slow pattern's counts
        pre = 16'h0003;
        measure();
        chk(1, 3);
        pre = 16'h0001;
        $display("test ports done");
    endtask

    task t_fw;
        ax_a = 4'h9;
        fw = DLPD_FW_ERASE;
        measure();
        chk(8, 0);
        chk(7, 4);
        chk(6, 0);
        fw = DLPD_FW_COPY;
        measure();
        chk(8, 4);
        chk(7, 0);
        chk(6, 0);
        fw = DLPD_FW_FAIL;
        repeat (8) @(negedge clock_i);
        repeat (64) @(negedge clock_i) same("chaser", 6'h00, {5'h00, leds.ctrl_run_led & (leds.err_a_led | leds.err_b_led)});
        measure();
        for (int b = 6; b < 9; b++) same("chaser_lit", 6'h01, {5'h00, lit[b] > 0 && lit[b] < 256});
        $display("test firmware done");
    endtask

    // Watchdog well beyond the expected run of about 10200 clocks
    initial begin
        #200000;
        err_count++;
        $display("BAD watchdog exp done seen hang");
        close_out();
    end

    // Main sequence
    initial begin
        {reset_i, supply, safe_torque_off, mem_wr, dbl, startup, window} = 7'b1100000;
        {svc_link, svc_pkt, svc_str, variant, fb_link, fb_act, code} = 11'h000;
        bus = DLPD_BUS_NO_LINK;
        safe = DLPD_SAFE_PRE_RESET;
        ax_a = 4'h1;
        ax_b = 4'h1;
        fw = DLPD_FW_NORMAL;
        pre = 16'h0001;
        repeat (12) @(negedge clock_i);
        reset_i = 1'b0;
        t_start();
        t_bus();
        t_safe();
        t_run();
        t_err();
        t_ports();
        t_fw();
        close_out();
    end
endmodule
`default_nettype wire
